// file: design/sck_pkg.sv
package sck_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_LOCK_STATUS = 32'hFFFF0400;
  localparam logic [31:0] ADDR_POWER_KEY_PRE = 32'hFFFF0404;
  localparam logic [31:0] ADDR_POWER_DIVIDER = 32'hFFFF0408;
  localparam logic [31:0] ADDR_POWER_KEY_POST = 32'hFFFF040C;
  localparam logic [31:0] ADDR_SOURCE_KEY_PRE = 32'hFFFF0410;
  localparam logic [31:0] ADDR_SOURCE_SELECT = 32'hFFFF0414;
  localparam logic [31:0] ADDR_SOURCE_KEY_POST = 32'hFFFF0418;

  // Key values
  localparam logic [31:0] SOURCE_KEY_PRE = 32'h000000AA;
  localparam logic [31:0] SOURCE_KEY_POST = 32'h00000055;
  localparam logic [31:0] POWER_KEY_PRE = 32'h00000001;
  localparam logic [31:0] POWER_KEY_POST = 32'h000000F4;

  // Reset values
  localparam logic [7:0] POWER_RESET = 8'h79;
  localparam logic [7:0] SOURCE_RESET = 8'h00;

  // Field positions
  localparam int STAT_INT_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_XTAL_BIT = 2;
  localparam int PWR_CORE_BIT = 3;
  localparam int PWR_PERIPH_BIT = 4;
  localparam int PWR_PLL_BIT = 5;
  localparam int PWR_XTAL_BIT = 6;
  localparam int PWR_PREC_BIT = 7;
  localparam logic [7:0] PWR_WAKE_MASK = 8'h38;

  // Source select encodings
  localparam logic [1:0] SRC_LOW_POWER = 2'h0;
  localparam logic [1:0] SRC_PRECISION = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL = 2'h2;

  // Frequencies and dividers
  localparam int PLL_HZ = 20480000;
  localparam int ADC_HZ = 512000;
  localparam int ADC_DIV = PLL_HZ / ADC_HZ;
  localparam int OSC_REF_DIV = 4;
  localparam int LP_TIMER_DIV = 4;
  localparam int MEM_UNLOCKED_DIV = 8;

  // Lock time after wake-up
  localparam int CLK_HZ = 25000000;
  localparam int LOCK_TIME_US = 2000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * (CLK_HZ / 1000000);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    SCK_KEY_IDLE = 2'b00,
    SCK_KEY_ARMED = 2'b01,
    SCK_KEY_PENDING = 2'b10
  } sck_key_state_t;

  typedef enum logic [2:0] {
    SCK_SEL_NONE = 3'b000,
    SCK_SEL_STATUS = 3'b001,
    SCK_SEL_PWR_PRE = 3'b010,
    SCK_SEL_PWR_CTRL = 3'b011,
    SCK_SEL_PWR_POST = 3'b100,
    SCK_SEL_SRC_PRE = 3'b101,
    SCK_SEL_SRC_CTRL = 3'b110,
    SCK_SEL_SRC_POST = 3'b111
  } sck_sel_t;

  // One-cycle clock enable pulses
  typedef struct packed {
    logic core;
    logic adc;
    logic mem;
    logic timer;
    logic pll_ref;
  } sck_clk_en_t;

  // Power-up controls, high means powered
  typedef struct packed {
    logic prec_osc;
    logic crystal;
    logic pll;
    logic periph;
    logic core;
    logic low_power_osc;
  } sck_power_t;

endpackage

// file: design/sck_clock_control.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
module sck_clock_control #(
  parameter int LOCK_CYCLES = sck_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Oscillator and PLL side, sampled levels and pulses
  input wire logic low_power_osc,
  input wire logic precision_osc,
  input wire logic crystal_input_pin,
  input wire logic pll_tick,
  input wire logic pll_lock_raw,
  input wire logic wake_event,
  input wire logic adc_low_power,
  // Clock enables and controls
  output sck_pkg::sck_clk_en_t clk_en,
  output sck_pkg::sck_power_t power_up,
  output logic [1:0] pll_source,
  output logic lock_overdue
);

  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam logic [LW-1:0] LOCK_LAST = LW'(LOCK_CYCLES - 1);
  localparam logic [5:0] ADC_LAST = 6'(sck_pkg::ADC_DIV - 1);
  localparam logic [1:0] OSC_LAST = 2'(sck_pkg::OSC_REF_DIV - 1);
  localparam logic [1:0] TMR_LAST = 2'(sck_pkg::LP_TIMER_DIV - 1);
  localparam logic [2:0] MEM_LAST = 3'(sck_pkg::MEM_UNLOCKED_DIV - 1);
  // Bus state
  logic aw_held_reg;
  logic w_held_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // Registers
  logic [7:0] power_divider_reg;
  logic [7:0] source_select_reg;
  logic lock_int_reg;
  logic lock_prev_reg;
  sck_pkg::sck_key_state_t pwr_key_reg;
  sck_pkg::sck_key_state_t src_key_reg;
  logic [7:0] pwr_pend_reg;
  logic [7:0] src_pend_reg;
  // Clock generation state
  logic lp_prev_reg;
  logic prec_prev_reg;
  logic xtal_prev_reg;
  logic [1:0] lp_ref_cnt_reg;
  logic [1:0] prec_ref_cnt_reg;
  logic [1:0] tmr_cnt_reg;
  logic [6:0] core_cnt_reg;
  logic [5:0] adc_cnt_reg;
  logic [2:0] mem_cnt_reg;
  logic [LW-1:0] lock_cnt_reg;
  logic lock_wait_reg;
  logic lock_overdue_reg;
  sck_pkg::sck_clk_en_t clk_en_reg;
  sck_pkg::sck_power_t power_up_reg;
  // Bus handshakes
  wire aw_take = s_awvalid && !aw_held_reg;
  wire w_take = s_wvalid && !w_held_reg;
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire ar_take = s_arvalid && !rvalid_reg;
  // Key writes need all four strobes; key checks compare whole words
  wire wr_full = (w_strb_reg == 4'hF);
  // Address decoding
  sck_pkg::sck_sel_t wsel;
  sck_pkg::sck_sel_t rsel;
  function automatic sck_pkg::sck_sel_t decode(input logic [31:0] a);
    if (a == sck_pkg::ADDR_LOCK_STATUS) begin
      decode = sck_pkg::SCK_SEL_STATUS;
    end else if (a == sck_pkg::ADDR_POWER_KEY_PRE) begin
      decode = sck_pkg::SCK_SEL_PWR_PRE;
    end else if (a == sck_pkg::ADDR_POWER_DIVIDER) begin
      decode = sck_pkg::SCK_SEL_PWR_CTRL;
    end else if (a == sck_pkg::ADDR_POWER_KEY_POST) begin
      decode = sck_pkg::SCK_SEL_PWR_POST;
    end else if (a == sck_pkg::ADDR_SOURCE_KEY_PRE) begin
      decode = sck_pkg::SCK_SEL_SRC_PRE;
    end else if (a == sck_pkg::ADDR_SOURCE_SELECT) begin
      decode = sck_pkg::SCK_SEL_SRC_CTRL;
    end else if (a == sck_pkg::ADDR_SOURCE_KEY_POST) begin
      decode = sck_pkg::SCK_SEL_SRC_POST;
    end else begin
      decode = sck_pkg::SCK_SEL_NONE;
    end
  endfunction
  assign wsel = decode(aw_addr_reg);
  assign rsel = decode(s_araddr);
  wire wr_ok = wr_go && (wsel != sck_pkg::SCK_SEL_NONE);
  wire wr_pwr_pre = wr_ok && wr_full && (wsel == sck_pkg::SCK_SEL_PWR_PRE)
    && (w_data_reg == sck_pkg::POWER_KEY_PRE);
  wire wr_pwr_post = wr_ok && wr_full && (wsel == sck_pkg::SCK_SEL_PWR_POST)
    && (w_data_reg == sck_pkg::POWER_KEY_POST);
  wire wr_pwr_ctrl = wr_ok && (wsel == sck_pkg::SCK_SEL_PWR_CTRL);
  wire wr_src_pre = wr_ok && wr_full && (wsel == sck_pkg::SCK_SEL_SRC_PRE)
    && (w_data_reg == sck_pkg::SOURCE_KEY_PRE);
  wire wr_src_post = wr_ok && wr_full && (wsel == sck_pkg::SCK_SEL_SRC_POST)
    && (w_data_reg == sck_pkg::SOURCE_KEY_POST);
  wire wr_src_ctrl = wr_ok && (wsel == sck_pkg::SCK_SEL_SRC_CTRL);
  wire wr_status = wr_ok && (wsel == sck_pkg::SCK_SEL_STATUS);
  // Status read view
  wire [7:0] status_view = {5'h00, crystal_input_pin, pll_lock_raw,
    lock_int_reg};
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (rsel == sck_pkg::SCK_SEL_STATUS) begin
      rd_word = {24'h000000, status_view};
    end else if (rsel == sck_pkg::SCK_SEL_PWR_CTRL) begin
      rd_word = {24'h000000, power_divider_reg};
    end else if (rsel == sck_pkg::SCK_SEL_SRC_CTRL) begin
      rd_word = {24'h000000, source_select_reg};
    end
  end

  // Key sequencers: prewrite arms, control write parks, postwrite commits
  sck_pkg::sck_key_state_t pwr_key_next;
  sck_pkg::sck_key_state_t src_key_next;
  always_comb begin
    pwr_key_next = pwr_key_reg;
    if (wr_ok) begin
      case (pwr_key_reg)
        sck_pkg::SCK_KEY_ARMED: begin
          pwr_key_next = wr_pwr_ctrl ? sck_pkg::SCK_KEY_PENDING
            : (wr_pwr_pre ? sck_pkg::SCK_KEY_ARMED
            : sck_pkg::SCK_KEY_IDLE);
        end
        default: begin
          pwr_key_next = wr_pwr_pre ? sck_pkg::SCK_KEY_ARMED
            : sck_pkg::SCK_KEY_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    src_key_next = src_key_reg;
    if (wr_ok) begin
      case (src_key_reg)
        sck_pkg::SCK_KEY_ARMED: begin
          src_key_next = wr_src_ctrl ? sck_pkg::SCK_KEY_PENDING
            : (wr_src_pre ? sck_pkg::SCK_KEY_ARMED
            : sck_pkg::SCK_KEY_IDLE);
        end
        default: begin
          src_key_next = wr_src_pre ? sck_pkg::SCK_KEY_ARMED
            : sck_pkg::SCK_KEY_IDLE;
        end
      endcase
    end
  end

  wire pwr_commit = wr_pwr_post && (pwr_key_reg == sck_pkg::SCK_KEY_PENDING);
  wire src_commit = wr_src_post && (src_key_reg == sck_pkg::SCK_KEY_PENDING);
  wire pwr_park = wr_pwr_ctrl && (pwr_key_reg == sck_pkg::SCK_KEY_ARMED);
  wire src_park = wr_src_ctrl && (src_key_reg == sck_pkg::SCK_KEY_ARMED);
  // Wake-up restores power bits after any commit in the same cycle
  wire [7:0] power_divider_next =
    (pwr_commit ? pwr_pend_reg : power_divider_reg)
    | (wake_event ? sck_pkg::PWR_WAKE_MASK : 8'h00);
  // Sticky lock-loss flag, set wins over a clearing write
  wire lock_fall = lock_prev_reg && !pll_lock_raw;
  wire lock_clr = wr_status && w_strb_reg[0]
    && w_data_reg[sck_pkg::STAT_INT_BIT];
  wire lock_int_next = lock_fall || (lock_int_reg && !lock_clr);
  // Oscillator edges and divided references
  wire lp_rise = low_power_osc && !lp_prev_reg;
  wire prec_rise = precision_osc && !prec_prev_reg;
  wire xtal_rise = crystal_input_pin && !xtal_prev_reg;
  wire lp_ref = lp_rise && (lp_ref_cnt_reg == OSC_LAST);
  wire prec_ref = prec_rise && (prec_ref_cnt_reg == OSC_LAST);
  wire [1:0] src_sel = source_select_reg[1:0];
  wire ref_next = (src_sel == sck_pkg::SRC_LOW_POWER) ? lp_ref
    : (src_sel == sck_pkg::SRC_PRECISION) ? prec_ref
    : (src_sel == sck_pkg::SRC_CRYSTAL) ? xtal_rise
    : 1'b0;
  // Core divider: code n divides by 2**n; a smaller code takes effect at once
  wire [2:0] cd = power_divider_reg[2:0];
  wire [6:0] core_last = 7'((8'h01 << cd) - 8'h01);
  wire core_wrap = core_cnt_reg >= core_last;
  wire core_next = pll_tick && core_wrap;
  wire adc_wrap = adc_cnt_reg == ADC_LAST;
  wire adc_next = adc_low_power ? lp_rise : (pll_tick && adc_wrap);
  wire mem_next = pll_tick
    && (pll_lock_raw || (mem_cnt_reg == MEM_LAST));
  wire tmr_next = lp_rise && (tmr_cnt_reg == TMR_LAST);
  // Bus channels
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= sck_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wsel == sck_pkg::SCK_SEL_NONE) ? sck_pkg::RESP_DECERR
          : sck_pkg::RESP_OKAY;
      end else if (bvalid_reg && s_bready) begin
        bvalid_reg <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= sck_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= (rsel == sck_pkg::SCK_SEL_NONE) ? sck_pkg::RESP_DECERR
        : sck_pkg::RESP_OKAY;
    end else if (rvalid_reg && s_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  // Protected registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_divider_reg <= sck_pkg::POWER_RESET;
      source_select_reg <= sck_pkg::SOURCE_RESET;
      pwr_key_reg <= sck_pkg::SCK_KEY_IDLE;
      src_key_reg <= sck_pkg::SCK_KEY_IDLE;
      pwr_pend_reg <= 8'h00;
      src_pend_reg <= 8'h00;
      lock_int_reg <= 1'b0;
      lock_prev_reg <= 1'b0;
    end else begin
      pwr_key_reg <= pwr_key_next;
      src_key_reg <= src_key_next;
      if (pwr_park) begin
        pwr_pend_reg <= w_data_reg[7:0];
      end
      if (src_park) begin
        src_pend_reg <= w_data_reg[7:0];
      end
      power_divider_reg <= power_divider_next;
      if (src_commit) begin
        source_select_reg <= src_pend_reg;
      end
      lock_int_reg <= lock_int_next;
      lock_prev_reg <= pll_lock_raw;
    end
  end
  // Clock dividers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lp_prev_reg <= 1'b0;
      prec_prev_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
      lp_ref_cnt_reg <= 2'h0;
      prec_ref_cnt_reg <= 2'h0;
      tmr_cnt_reg <= 2'h0;
      core_cnt_reg <= 7'h00;
      adc_cnt_reg <= 6'h00;
      mem_cnt_reg <= 3'h0;
    end else begin
      lp_prev_reg <= low_power_osc;
      prec_prev_reg <= precision_osc;
      xtal_prev_reg <= crystal_input_pin;
      if (lp_rise) begin
        lp_ref_cnt_reg <= lp_ref_cnt_reg + 2'h1;
        tmr_cnt_reg <= tmr_cnt_reg + 2'h1;
      end
      if (prec_rise) begin
        prec_ref_cnt_reg <= prec_ref_cnt_reg + 2'h1;
      end
      if (pll_tick) begin
        core_cnt_reg <= core_wrap ? 7'h00 : core_cnt_reg + 7'h01;
        adc_cnt_reg <= adc_wrap ? 6'h00 : adc_cnt_reg + 6'h01;
        mem_cnt_reg <= mem_cnt_reg + 3'h1;
      end
    end
  end
  // Lock watch after wake-up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_reg <= '0;
      lock_wait_reg <= 1'b0;
      lock_overdue_reg <= 1'b0;
    end else if (wake_event) begin
      lock_cnt_reg <= '0;
      lock_wait_reg <= 1'b1;
      lock_overdue_reg <= 1'b0;
    end else if (lock_wait_reg) begin
      if (pll_lock_raw) begin
        lock_wait_reg <= 1'b0;
      end else if (lock_cnt_reg == LOCK_LAST) begin
        lock_wait_reg <= 1'b0;
        lock_overdue_reg <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + LW'(1);
      end
    end
  end
  // Registered outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_en_reg <= '0;
      power_up_reg <= '{low_power_osc: 1'b1, default: 1'b0};
    end else begin
      clk_en_reg <= '{core: core_next, adc: adc_next, mem: mem_next,
        timer: tmr_next, pll_ref: ref_next};
      power_up_reg <= '{
        prec_osc: power_divider_reg[sck_pkg::PWR_PREC_BIT],
        crystal: power_divider_reg[sck_pkg::PWR_XTAL_BIT],
        pll: power_divider_reg[sck_pkg::PWR_PLL_BIT],
        periph: power_divider_reg[sck_pkg::PWR_PERIPH_BIT],
        core: power_divider_reg[sck_pkg::PWR_CORE_BIT],
        low_power_osc: 1'b1};
    end
  end
  assign s_awready = !aw_held_reg;
  assign s_wready = !w_held_reg;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_arready = !rvalid_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rdata = rdata_reg;
  assign s_rresp = rresp_reg;
  assign clk_en = clk_en_reg;
  assign power_up = power_up_reg;
  assign pll_source = source_select_reg[1:0];
  assign lock_overdue = lock_overdue_reg;
endmodule

// file: sim/sck_clock_control_monitor.sv
`timescale 1ns/100ps
module sck_clock_control_monitor #(
  parameter int LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // Clock side
  input wire logic pll_tick,
  input wire logic pll_lock_raw,
  input wire logic wake_event,
  input sck_pkg::sck_clk_en_t clk_en,
  input sck_pkg::sck_power_t power_up,
  input wire logic lock_overdue
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_wresp_held: assert property (
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data changed before taken");
  a_read_answer: assert property (
    s_arvalid && s_arready |=> s_rvalid)
    else $error("read not answered next cycle");
  a_read_blocked: assert property (s_rvalid |-> !s_arready)
    else $error("read address taken while data pending");
  a_addr_taken: assert property (
    s_awvalid && s_awready |=> !s_awready)
    else $error("write address ready stayed high after take");
  // Oscillator must survive every power setting, checked after first edge
  a_lp_alive: assert property ($past(rst_n) |-> power_up.low_power_osc)
    else $error("low power oscillator stopped");
  a_mem_locked: assert property (
    pll_lock_raw [*3] ##0 pll_tick |=> clk_en.mem)
    else $error("memory enable missing while locked");
  a_core_tick: assert property (!pll_tick |=> !clk_en.core)
    else $error("core enable without a pll tick");
  a_wake_power: assert property (
    wake_event |-> ##[1:2] (power_up.pll && power_up.periph && power_up.core))
    else $error("wake-up did not restore power bits");
  a_overdue_clear: assert property (wake_event |=> !lock_overdue)
    else $error("lock overdue not cleared by wake-up");
endmodule

bind sck_clock_control sck_clock_control_monitor #(
  .LOCK_CYCLES(LOCK_CYCLES)
) u_mon (
  .clock(clock), .rst_n(rst_n), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
  .s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
  .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .pll_tick(pll_tick), .pll_lock_raw(pll_lock_raw),
  .wake_event(wake_event), .clk_en(clk_en), .power_up(power_up),
  .lock_overdue(lock_overdue)
);

// file: sim/sck_clock_control_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module sck_clock_control_tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } sck_row_t;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [31:0] s_awaddr = 32'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [31:0] s_araddr = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awvalid = 1'h0;
  logic s_wvalid = 1'h0;
  logic s_bready = 1'h0;
  logic s_arvalid = 1'h0;
  logic s_rready = 1'h0;
  logic low_power_osc = 1'h0;
  logic precision_osc = 1'h0;
  logic crystal_input_pin = 1'h0;
  logic pll_tick = 1'h0;
  logic pll_lock_raw = 1'h0;
  logic wake_event = 1'h0;
  logic adc_low_power = 1'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, lock_overdue;
  logic [1:0] s_bresp, s_rresp, pll_source, rs;
  logic [31:0] s_rdata, rd_v;
  sck_pkg::sck_clk_en_t clk_en;
  sck_pkg::sck_power_t power_up;
  logic [2:0] osc_cnt = 3'h0;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  // Offsets from 0xFFFF0400; reads of resp 3 skip the data compare
  sck_row_t rows [32] = '{
    '{1'h0, 8'h08, 32'h79, 2'h0}, '{1'h0, 8'h14, 32'h00, 2'h0},
    '{1'h1, 8'h10, 32'hAA, 2'h0}, '{1'h1, 8'h14, 32'h01, 2'h0},
    '{1'h1, 8'h18, 32'h55, 2'h0}, '{1'h0, 8'h14, 32'h01, 2'h0},
    '{1'h1, 8'h10, 32'hAA, 2'h0}, '{1'h1, 8'h14, 32'h02, 2'h0},
    '{1'h1, 8'h18, 32'h55, 2'h0}, '{1'h0, 8'h14, 32'h02, 2'h0},
    '{1'h1, 8'h14, 32'h01, 2'h0}, '{1'h0, 8'h14, 32'h02, 2'h0},
    '{1'h1, 8'h10, 32'hAA, 2'h0}, '{1'h1, 8'h14, 32'h00, 2'h0},
    '{1'h1, 8'h18, 32'h56, 2'h0}, '{1'h0, 8'h14, 32'h02, 2'h0},
    '{1'h1, 8'h10, 32'hAA, 2'h0}, '{1'h1, 8'h04, 32'h01, 2'h0},
    '{1'h1, 8'h14, 32'h00, 2'h0}, '{1'h1, 8'h18, 32'h55, 2'h0},
    '{1'h0, 8'h14, 32'h02, 2'h0}, '{1'h1, 8'h10, 32'hAA, 2'h0},
    '{1'h1, 8'h14, 32'h00, 2'h0}, '{1'h1, 8'h18, 32'h55, 2'h0},
    '{1'h0, 8'h14, 32'h00, 2'h0}, '{1'h1, 8'h04, 32'h01, 2'h0},
    '{1'h1, 8'h08, 32'h78, 2'h0}, '{1'h1, 8'h0C, 32'hF4, 2'h0},
    '{1'h0, 8'h08, 32'h78, 2'h0}, '{1'h0, 8'h10, 32'h00, 2'h0},
    '{1'h1, 8'h1C, 32'h00, 2'h3}, '{1'h0, 8'h1C, 32'h00, 2'h3}};

  sck_clock_control #(.LOCK_CYCLES(20)) i_dut (
    .clock(clock), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .low_power_osc(low_power_osc),
    .precision_osc(precision_osc), .crystal_input_pin(crystal_input_pin),
    .pll_tick(pll_tick), .pll_lock_raw(pll_lock_raw),
    .wake_event(wake_event), .adc_low_power(adc_low_power),
    .clk_en(clk_en), .power_up(power_up), .pll_source(pll_source),
    .lock_overdue(lock_overdue));

  always #20 clock = ~clock;

  // Tick every second cycle, oscillators with an eight cycle period
  always @(posedge clock) begin
    pll_tick <= ~pll_tick;
    osc_cnt <= osc_cnt + 3'h1;
    low_power_osc <= osc_cnt[2];
    precision_osc <= ~osc_cnt[2];
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic ha;
    logic hw;
    logic hb;
    @(posedge clock);
    s_awaddr <= {24'hFFFF04, a};
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge clock);
      ha = s_awvalid && s_awready;
      hw = s_wvalid && s_wready;
      hb = s_bvalid;
      r = s_bresp;
      @(posedge clock);
      if (ha) s_awvalid <= 1'h0;
      if (hw) s_wvalid <= 1'h0;
    end
    s_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic ha;
    logic hr;
    @(posedge clock);
    s_araddr <= {24'hFFFF04, a};
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    hr = 1'h0;
    while (!hr) begin
      @(negedge clock);
      ha = s_arvalid && s_arready;
      hr = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      @(posedge clock);
      if (ha) s_arvalid <= 1'h0;
    end
    s_rready <= 1'h0;
  endtask

  task automatic keyed(input logic [7:0] a, input logic [31:0] k0, v, k1);
    wr(a - 8'h4, k0, rs);
    wr(a, v, rs);
    wr(a + 8'h4, k1, rs);
  endtask

  // Windows are whole periods, so the count does not depend on phase
  task automatic cnt(input int b, input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clock);
      c += int'(clk_en[b]);
    end
    `CHK("pulse count", e, c)
    $display("count test on enable %0d done", b);
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    cnt(4, 64, 16);
    cnt(3, 800, 10);
    cnt(1, 800, 25);
    cnt(0, 800, 25);
    cnt(2, 160, 10);
    `CHK("lp power", 1'h1, power_up.low_power_osc)
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rs);
      else rd(rows[i].a, rd_v, rs);
      `CHK("resp", rows[i].r, rs)
      if (!rows[i].w && rows[i].r == 2'h0)
        `CHK("data", rows[i].d, rd_v)
      if (!rows[i].w && rows[i].a == 8'h14)
        `CHK("src", rows[i].d[1:0], pll_source)
    end
    $display("register table done");
    cnt(4, 64, 32);
    keyed(8'h08, 32'h01, 32'h7F, 32'hF4);
    cnt(4, 1024, 4);
    keyed(8'h14, 32'hAA, 32'h01, 32'h55);
    @(posedge clock);
    cnt(0, 800, 25);
    keyed(8'h14, 32'hAA, 32'h03, 32'h55);
    cnt(0, 320, 0);
    @(posedge clock);
    adc_low_power <= 1'h1;
    repeat (4) @(posedge clock);
    cnt(3, 800, 100);
    @(posedge clock);
    adc_low_power <= 1'h0;
    pll_lock_raw <= 1'h1;
    crystal_input_pin <= 1'h1;
    repeat (4) @(posedge clock);
    cnt(2, 160, 80);
    rd(8'h00, rd_v, rs);
    `CHK("status", 32'h6, rd_v)
    pll_lock_raw <= 1'h0;
    crystal_input_pin <= 1'h0;
    rd(8'h00, rd_v, rs);
    `CHK("status", 32'h1, rd_v)
    wr(8'h00, 32'h1, rs);
    rd(8'h00, rd_v, rs);
    `CHK("status", 32'h0, rd_v)
    $display("lock status test done");
    keyed(8'h14, 32'hAA, 32'h00, 32'h55);
    keyed(8'h08, 32'h01, 32'h47, 32'hF4);
    @(negedge clock);
    `CHK("pll power", 1'h0, power_up.pll)
    @(posedge clock);
    wake_event <= 1'h1;
    @(posedge clock);
    wake_event <= 1'h0;
    rd(8'h08, rd_v, rs);
    `CHK("power reg", 32'h7F, rd_v)
    `CHK("overdue early", 1'h0, lock_overdue)
    repeat (30) @(posedge clock);
    `CHK("overdue", 1'h1, lock_overdue)
    pll_lock_raw <= 1'h1;
    wake_event <= 1'h1;
    @(posedge clock);
    wake_event <= 1'h0;
    repeat (30) @(posedge clock);
    `CHK("overdue", 1'h0, lock_overdue)
    rd(8'h00, rd_v, rs);
    `CHK("lock poll", 32'h2, rd_v)
    $display("wake-up test done");
    // Mid-run reset, then an unkeyed write that must not land
    rst_n <= 1'h0;
    @(negedge clock);
    `CHK("reset enables", 5'h00, clk_en)
    `CHK("reset power", 6'h01, power_up)
    @(posedge clock);
    rst_n <= 1'h1;
    wr(8'h08, 32'h00, rs);
    rd(8'h08, rd_v, rs);
    `CHK("power reset", 32'h79, rd_v)
    `CHK("overdue reset", 1'h0, lock_overdue)
    `CHK("source reset", 2'h0, pll_source)
    $display("reset test done");
    final_report();
  end
endmodule
